// ---- fsr_status_two.sv ----
// Operation status register two with APB access and interrupt logic
// Behaviour
// R01 - Bits 7..5 reserved, always read zero
// R02 - Bit 4 high while integrity CRC suspended
// R03 - Short CRC range sets abort, skips calculation
// R04 - Valid CRC range start clears abort flag
// R05 - Host evaluates sector before reading result bit
// R06 - Bit 2 follows last sector erase evaluation
// R07 - Bit 1 high while erase suspended
// R08 - Bit 0 high while program suspended
// R09 - Host trusts register only when not busy
// R10 - Host ignores register during any reset
// R11 - Ready/busy bit high while embedded operation runs
// R12 - Register read-only; writes change nothing
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module fsr_status_two
   import fsr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [fsr_pkg::FSR_PADDR_W-1:0] paddr_i,
   input wire logic [fsr_pkg::FSR_DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [fsr_pkg::FSR_DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Embedded operation engine
   input wire logic embedded_busy_i,
   input wire logic crc_suspended_i,
   input wire logic crc_req_i,
   input wire logic [fsr_pkg::FSR_FLASH_ADDR_W-1:0] crc_start_address_i,
   input wire logic [fsr_pkg::FSR_FLASH_ADDR_W-1:0] crc_end_address_i,
   input wire logic erase_eval_done_i,
   input wire logic sector_erased_i,
   input wire logic erase_suspended_i,
   input wire logic program_suspended_i,
   output logic crc_run_o,
   // Status view and interrupt
   output logic [fsr_pkg::FSR_STAT_W-1:0] operation_status_two_o,
   output logic ready_busy_flag_o,
   output logic irq_o
);

   // ************************************************************
   // Declarations
   // ************************************************************

   // Status flags
   logic crc_susp_q;
   logic crc_abort_q;
   logic crc_abort_d;
   logic sector_ok_q;
   logic sector_ok_d;
   logic erase_susp_q;
   logic prog_susp_q;
   logic busy_q;

   // Interrupt registers
   logic [FSR_IRQ_W-1:0] irq_status_q;
   logic [FSR_IRQ_W-1:0] irq_status_d;
   logic [FSR_IRQ_W-1:0] irq_enable_q;
   logic [FSR_IRQ_W-1:0] irq_enable_d;

   // APB answer path
   fsr_apb_state_e apb_state_q;
   fsr_apb_state_e apb_state_d;
   logic [FSR_DATA_W-1:0] prdata_q;
   logic [FSR_DATA_W-1:0] prdata_d;
   logic pready_q;
   logic pslverr_q;
   logic pslverr_d;
   logic irq_q;

   // Pulses from the CRC range gate
   wire logic crc_run_w;
   wire logic crc_abort_set_w;
   wire logic crc_abort_clr_w;

   // ************************************************************
   // Limitations
   // ************************************************************

   // Flags clear to zero on reset; the host must not trust them until ready
   // Busy is mirrored from the engine; nothing here generates it
   // The CRC, suspend and erase engines sit outside; only levels and pulses arrive
   // The reserved bits have no storage, so no write can ever set them
   // Bus writes reach only the interrupt clear and enable registers
   // Every level is seen one edge late, so a host polls rather than races

   // ************************************************************
   // CRC request range gate
   // ************************************************************

   // Kept separate so the address arithmetic stays out of the bus path
   fsr_crc_gate u_crc_gate (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .crc_req_i(crc_req_i),
      .crc_start_address_i(crc_start_address_i),
      .crc_end_address_i(crc_end_address_i),
      .crc_run_o(crc_run_w),
      .crc_abort_set_o(crc_abort_set_w),
      .crc_abort_clr_o(crc_abort_clr_w)
   );

   // ************************************************************
   // Register view
   // ************************************************************

   // Assembled views of the two status registers
   wire logic [FSR_STAT_W-1:0] status_two_w;
   wire logic [FSR_STAT_W-1:0] status_one_w;

   // Reserved bits forced, no storage behind them
   assign status_two_w[FSR_RSVD_MSB:FSR_RSVD_LSB] = FSR_RSVD_VALUE; // R01
   assign status_two_w[FSR_BIT_CRC_SUSP] = crc_susp_q;
   assign status_two_w[FSR_BIT_CRC_ABORT] = crc_abort_q;
   assign status_two_w[FSR_BIT_SECTOR_OK] = sector_ok_q;
   assign status_two_w[FSR_BIT_ERASE_SUSP] = erase_susp_q;
   assign status_two_w[FSR_BIT_PROG_SUSP] = prog_susp_q;

   // Only the ready/busy bit lives in status one here
   assign status_one_w = {{(FSR_STAT_W-1){1'b0}}, busy_q};

   // ************************************************************
   // Flag next values
   // ************************************************************

   // A set in the same cycle as a clear cannot happen: one request gives one pulse
   assign crc_abort_d = crc_abort_set_w ? 1'b1 :
                        crc_abort_clr_w ? 1'b0 : crc_abort_q; // R03 R04

   // Result only moves when an evaluation finishes
   assign sector_ok_d = erase_eval_done_i ? sector_erased_i : sector_ok_q; // R06

   // Level flags follow the engine one cycle later
   // A read taken at the edge of a change still returns the old level
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         crc_susp_q <= 1'b0;
         erase_susp_q <= 1'b0;
         prog_susp_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         crc_susp_q <= crc_suspended_i; // R02
         erase_susp_q <= erase_suspended_i; // R07
         prog_susp_q <= program_suspended_i; // R08
         busy_q <= embedded_busy_i; // R11
      end
   end

   // Event-driven flags; no bus path reaches them
   // A stray bus write is therefore harmless to them
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         crc_abort_q <= 1'b0;
         sector_ok_q <= 1'b0;
      end else begin
         crc_abort_q <= crc_abort_d; // R12
         sector_ok_q <= sector_ok_d; // R12
      end
   end

   // ************************************************************
   // Interrupt events
   // ************************************************************

   // Event strobes, each one cycle long
   wire logic ready_evt_w;
   wire logic suspend_evt_w;
   wire logic [FSR_IRQ_W-1:0] irq_events_w;

   // Busy falling means the device is back in standby
   assign ready_evt_w = busy_q & ~embedded_busy_i;

   // Rising level against its registered copy
   function automatic logic level_rose(input logic now_a, input logic was_a);
      level_rose = now_a & ~was_a;
   endfunction : level_rose

   // Any suspend flag rising
   assign suspend_evt_w = level_rose(crc_suspended_i, crc_susp_q) |
                          level_rose(erase_suspended_i, erase_susp_q) |
                          level_rose(program_suspended_i, prog_susp_q);

   // Event map into the sticky status bits
   assign irq_events_w[FSR_IRQ_CRC_ABORT] = crc_abort_set_w;
   assign irq_events_w[FSR_IRQ_EVAL_DONE] = erase_eval_done_i;
   assign irq_events_w[FSR_IRQ_READY] = ready_evt_w;
   assign irq_events_w[FSR_IRQ_SUSPEND] = suspend_evt_w;

   // ************************************************************
   // APB decode
   // ************************************************************

   // Address decode and bus qualifiers
   wire logic access_w;
   wire logic commit_w;
   wire logic wr_commit_w;
   wire logic hit_status_two_w;
   wire logic hit_status_one_w;
   wire logic hit_irq_status_w;
   wire logic hit_irq_clear_w;
   wire logic hit_irq_enable_w;
   wire logic mapped_w;
   wire logic [FSR_IRQ_W-1:0] lane0_w;

   // Whole-byte match; a misaligned address hits nothing and is refused
   function automatic logic addr_is(input logic [FSR_PADDR_W-1:0] addr_a, input logic [FSR_PADDR_W-1:0] off_a);
      addr_is = (addr_a == off_a);
   endfunction : addr_is

   assign hit_status_two_w = addr_is(paddr_i, FSR_OFF_STATUS_TWO);
   assign hit_status_one_w = addr_is(paddr_i, FSR_OFF_STATUS_ONE);
   assign hit_irq_status_w = addr_is(paddr_i, FSR_OFF_IRQ_STATUS);
   assign hit_irq_clear_w = addr_is(paddr_i, FSR_OFF_IRQ_CLEAR);
   assign hit_irq_enable_w = addr_is(paddr_i, FSR_OFF_IRQ_ENABLE);
   // Anything else on the bus answers an error
   assign mapped_w = hit_status_two_w | hit_status_one_w | hit_irq_status_w |
                     hit_irq_clear_w | hit_irq_enable_w;

   // Access phase seen while no answer is pending
   // A second access cannot start while an answer is still out
   assign access_w = psel_i & penable_i & (apb_state_q == FSR_APB_IDLE);

   // The edge where the master sees pready high
   assign commit_w = psel_i & penable_i & pready_q;
   assign wr_commit_w = commit_w & pwrite_i & ~pslverr_q;

   // Only byte lane 0 carries the narrow fields
   // Strobes of the other lanes are ignored; nothing is stored there
   assign lane0_w = pstrb_i[0] ? pwdata_i[FSR_IRQ_W-1:0] : {FSR_IRQ_W{1'b0}};

   // ************************************************************
   // Interrupt registers
   // ************************************************************

   // Set wins over a clear that lands in the same cycle
   // so an event racing a clear is never lost
   assign irq_status_d = irq_events_w |
                         (irq_status_q & ~((wr_commit_w & hit_irq_clear_w) ? lane0_w : {FSR_IRQ_W{1'b0}}));

   // Enable keeps unwritten lanes
   assign irq_enable_d = (wr_commit_w & hit_irq_enable_w & pstrb_i[0]) ?
                         pwdata_i[FSR_IRQ_W-1:0] : irq_enable_q;

   // Interrupt line built from next values so it trails its cause by one edge
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_status_q <= FSR_IRQ_RST;
         irq_enable_q <= FSR_IRQ_RST;
         irq_q <= 1'b0;
      end else begin
         irq_status_q <= irq_status_d;
         irq_enable_q <= irq_enable_d;
         irq_q <= |(irq_status_d & irq_enable_d);
      end
   end

   // ************************************************************
   // APB answer
   // ************************************************************

   // Read mux; writes to the status registers are ignored, not refused
   always_comb begin
      prdata_d = FSR_RDATA_RST;
      if (!pwrite_i) begin
         if (hit_status_two_w) begin
            prdata_d[FSR_STAT_W-1:0] = status_two_w; // R01
         end else if (hit_status_one_w) begin
            prdata_d[FSR_STAT_W-1:0] = status_one_w; // R11
         end else if (hit_irq_status_w) begin
            prdata_d[FSR_IRQ_W-1:0] = irq_status_q;
         end else if (hit_irq_enable_w) begin
            prdata_d[FSR_IRQ_W-1:0] = irq_enable_q;
         end else begin
            prdata_d = FSR_RDATA_RST;
         end
      end
   end

   // Unmapped addresses and reads of the clear register answer an error
   assign pslverr_d = ~mapped_w | (~pwrite_i & hit_irq_clear_w);

   // One wait state: answer registered, so outputs come from flops
   // Costs a cycle per access but keeps every bus output on a flop
   always_comb begin
      apb_state_d = apb_state_q;
      case (apb_state_q)
         FSR_APB_IDLE: begin
            if (access_w) begin
               apb_state_d = FSR_APB_ANSWER;
            end
         end
         FSR_APB_ANSWER: begin
            apb_state_d = FSR_APB_IDLE;
         end
         default: begin
            apb_state_d = FSR_APB_IDLE;
         end
      endcase
   end

   // Read data frozen at the access edge; zero outside the answer cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         apb_state_q <= FSR_APB_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= FSR_RDATA_RST;
      end else begin
         apb_state_q <= apb_state_d;
         pready_q <= access_w;
         pslverr_q <= access_w & pslverr_d;
         prdata_q <= access_w ? prdata_d : FSR_RDATA_RST;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Status copies registered once more so readers see flop outputs
   // They trail the read view by one more edge
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         operation_status_two_o <= FSR_STATUS_TWO_RST;
         ready_busy_flag_o <= 1'b0;
         crc_run_o <= 1'b0;
      end else begin
         operation_status_two_o <= status_two_w; // R01
         ready_busy_flag_o <= busy_q; // R11
         crc_run_o <= crc_run_w; // R03
      end
   end

   // Bus and interrupt ports straight from their flops
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o = irq_q;

endmodule : fsr_status_two

// ---- fsr_pkg.sv ----
// Constants shared by the operation status register bank
package fsr_pkg;

   // ************************************************************
   // Bus and field widths
   // ************************************************************
   localparam int unsigned FSR_DATA_W = 32;
   localparam int unsigned FSR_PADDR_W = 8;
   localparam int unsigned FSR_STAT_W = 8;
   localparam int unsigned FSR_FLASH_ADDR_W = 32;
   localparam int unsigned FSR_IRQ_W = 4;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [FSR_PADDR_W-1:0] FSR_OFF_STATUS_TWO = 8'h00;
   localparam logic [FSR_PADDR_W-1:0] FSR_OFF_STATUS_ONE = 8'h04;
   localparam logic [FSR_PADDR_W-1:0] FSR_OFF_IRQ_STATUS = 8'h08;
   localparam logic [FSR_PADDR_W-1:0] FSR_OFF_IRQ_CLEAR = 8'h0C;
   localparam logic [FSR_PADDR_W-1:0] FSR_OFF_IRQ_ENABLE = 8'h10;

   // ************************************************************
   // Field positions of operation_status_two
   // ************************************************************
   localparam int unsigned FSR_BIT_PROG_SUSP = 0;
   localparam int unsigned FSR_BIT_ERASE_SUSP = 1;
   localparam int unsigned FSR_BIT_SECTOR_OK = 2;
   localparam int unsigned FSR_BIT_CRC_ABORT = 3;
   localparam int unsigned FSR_BIT_CRC_SUSP = 4;
   localparam int unsigned FSR_RSVD_LSB = 5;
   localparam int unsigned FSR_RSVD_MSB = 7;
   localparam logic [2:0] FSR_RSVD_VALUE = 3'h0;

   // Field position of ready_busy_flag in operation_status_one
   localparam int unsigned FSR_BIT_READY_BUSY = 0;

   // ************************************************************
   // Interrupt status bit positions
   // ************************************************************
   localparam int unsigned FSR_IRQ_CRC_ABORT = 0;
   localparam int unsigned FSR_IRQ_EVAL_DONE = 1;
   localparam int unsigned FSR_IRQ_READY = 2;
   localparam int unsigned FSR_IRQ_SUSPEND = 3;

   // ************************************************************
   // Values after reset and counts
   // ************************************************************
   localparam logic [FSR_STAT_W-1:0] FSR_STATUS_TWO_RST = 8'h00;
   localparam logic [FSR_IRQ_W-1:0] FSR_IRQ_RST = 4'h0;
   localparam logic [FSR_DATA_W-1:0] FSR_RDATA_RST = 32'h0000_0000;
   localparam logic [FSR_FLASH_ADDR_W:0] FSR_CRC_MIN_SPAN = 33'h0_0000_0003;

   // APB access phase states
   typedef enum logic [0:0] {
      FSR_APB_IDLE,
      FSR_APB_ANSWER
   } fsr_apb_state_e;

endpackage : fsr_pkg

// ---- fsr_crc_gate.sv ----
// Range check of integrity CRC requests, drives the abort flag
`timescale 1ns/1ps
module fsr_crc_gate
   import fsr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic crc_req_i,
   input wire logic [fsr_pkg::FSR_FLASH_ADDR_W-1:0] crc_start_address_i,
   input wire logic [fsr_pkg::FSR_FLASH_ADDR_W-1:0] crc_end_address_i,
   output logic crc_run_o,
   output logic crc_abort_set_o,
   output logic crc_abort_clr_o
);

   // ************************************************************
   // Range test
   // ************************************************************

   // Sum kept one bit wider so a start near the top cannot wrap
   function automatic logic span_too_short(input logic [FSR_FLASH_ADDR_W-1:0] start_a,
                                           input logic [FSR_FLASH_ADDR_W-1:0] end_a);
      logic [FSR_FLASH_ADDR_W:0] lim;
      lim = {1'b0, start_a} + FSR_CRC_MIN_SPAN;
      span_too_short = ({1'b0, end_a} < lim);
   endfunction : span_too_short

   wire logic short_w;

   assign short_w = span_too_short(crc_start_address_i, crc_end_address_i);

   // One-cycle pulses; a short range never starts the engine
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         crc_run_o <= 1'b0;
         crc_abort_set_o <= 1'b0;
         crc_abort_clr_o <= 1'b0;
      end else begin
         crc_run_o <= crc_req_i & ~short_w; // R04
         crc_abort_set_o <= crc_req_i & short_w; // R03
         crc_abort_clr_o <= crc_req_i & ~short_w; // R04
      end
   end

endmodule : fsr_crc_gate

// ---- fsr_status_two_assertions.sv ----
// Concurrent checks on the ports of the operation status register bank
`timescale 1ns/1ps
module fsr_status_two_assertions
   import fsr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [fsr_pkg::FSR_PADDR_W-1:0] paddr_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic embedded_busy_i,
   input wire logic crc_suspended_i,
   input wire logic crc_req_i,
   input wire logic [fsr_pkg::FSR_FLASH_ADDR_W-1:0] crc_start_address_i,
   input wire logic [fsr_pkg::FSR_FLASH_ADDR_W-1:0] crc_end_address_i,
   input wire logic erase_eval_done_i,
   input wire logic sector_erased_i,
   input wire logic erase_suspended_i,
   input wire logic program_suspended_i,
   input wire logic crc_run_o,
   input wire logic [fsr_pkg::FSR_STAT_W-1:0] operation_status_two_o,
   input wire logic ready_busy_flag_o
);
   logic [1:0] up_q;
   logic [1:0] up_d;
   logic short_w;
   // Settle count: levels launched during reset must not be compared
   assign up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   assign short_w = {1'b0, crc_end_address_i} < ({1'b0, crc_start_address_i} + FSR_CRC_MIN_SPAN);
   // Counter of edges since reset release
   always_ff @(posedge clk_sys_i) begin
      up_q <= rst_i ? 2'h0 : up_d;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   rsvd_zero_a: assert property (operation_status_two_o[7:5] == FSR_RSVD_VALUE)
      else $error("reserved bits not zero");
   crc_susp_a: assert property (up_q == 2'h3 |-> operation_status_two_o[4] == $past(crc_suspended_i, 2))
      else $error("crc suspend bit wrong");
   abort_set_a: assert property (crc_req_i && short_w |-> ##2 !crc_run_o ##1 operation_status_two_o[3])
      else $error("short crc span not aborted");
   abort_clear_a: assert property (crc_req_i && !short_w |-> ##2 crc_run_o ##1 !operation_status_two_o[3])
      else $error("valid crc span not started");
   sector_result_a: assert property (erase_eval_done_i |-> ##2 operation_status_two_o[2] == $past(sector_erased_i, 2))
      else $error("sector result bit wrong");
   erase_susp_a: assert property (up_q == 2'h3 |-> operation_status_two_o[1] == $past(erase_suspended_i, 2))
      else $error("erase suspend bit wrong");
   prog_susp_a: assert property (up_q == 2'h3 |-> operation_status_two_o[0] == $past(program_suspended_i, 2))
      else $error("program suspend bit wrong");
   busy_rise_a: assert property (up_q == 2'h3 && $rose(ready_busy_flag_o) |-> $past(embedded_busy_i) || $past(embedded_busy_i, 2))
      else $error("busy flag rose without cause");
   busy_flag_a: assert property (up_q == 2'h3 |-> ready_busy_flag_o == $past(embedded_busy_i, 2))
      else $error("ready busy flag wrong");
   run_cause_a: assert property (crc_run_o |-> $past(crc_req_i, 2) && !$past(short_w, 2))
      else $error("crc run without valid request");
   apb_answer_a: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o ##1 !pready_o)
      else $error("answer not one cycle after access");
   ro_write_a: assert property (pready_o && psel_i && pwrite_i && paddr_i == FSR_OFF_STATUS_TWO |-> !pslverr_o)
      else $error("write to status two flagged");
   cover property (crc_req_i && short_w);
   cover property (erase_eval_done_i && sector_erased_i);
   cover property (pready_o && pslverr_o);
endmodule : fsr_status_two_assertions

// ---- fsr_host_model.sv ----
// Host controller model: APB master reaching the register bank
`timescale 1ns/1ps
module fsr_host_model (
   input wire logic clk_sys_i,
   input wire logic pready_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [fsr_pkg::FSR_PADDR_W-1:0] paddr_o,
   output logic [fsr_pkg::FSR_DATA_W-1:0] pwdata_o
);
   // Idle bus at time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = '0;
   end
   // One transfer; called just after a rising edge, leaves one idle cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_sys_i);
      penable_o <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_i !== 1'b1) @(posedge clk_sys_i);
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d; // Released data must not look still valid
      @(posedge clk_sys_i);
   endtask : xfer
endmodule : fsr_host_model

// ---- flash_status_register_two_bench.sv ----
// Self-checking bench for the operation status register bank
`timescale 1ns/1ps
module flash_status_register_two_bench;
   import fsr_pkg::*;
   typedef struct packed {logic [31:0] d; logic e; logic c;} fsr_exp_s;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, crun, rbf, irq;
   logic busy = 0, csusp = 0, creq = 0, edone = 0, serased = 0, esusp = 0, psusp = 0;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, s;
   logic [31:0] cs = 0, ce = 0;
   logic [7:0] st2;
   fsr_exp_s q[$];
   fsr_exp_s x;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   fsr_status_two i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .embedded_busy_i(busy), .crc_suspended_i(csusp),
      .crc_req_i(creq), .crc_start_address_i(cs), .crc_end_address_i(ce), .erase_eval_done_i(edone),
      .sector_erased_i(serased), .erase_suspended_i(esusp), .program_suspended_i(psusp),
      .crc_run_o(crun), .operation_status_two_o(st2), .ready_busy_flag_o(rbf), .irq_o(irq));
   fsr_host_model i_host (.clk_sys_i(clk_sys_i), .pready_i(pready), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t got %0h expected %0h", $time, g, e);
      end
   endtask : cmp
   // Reads expect data unless refused; writes only a response code
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
      q.push_back('{d, e, !e});
      i_host.xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      q.push_back('{32'h0, e, 1'b0});
      i_host.xfer(1'b1, a, d);
   endtask : wr
   task automatic crc(input logic [31:0] a, input logic [31:0] b);
      creq <= 1'b1;
      cs <= a;
      ce <= b;
      @(posedge clk_sys_i);
      creq <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask : crc
   // Answer watcher; a hang is cut short by the cycle ceiling
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 4000) begin
         fail_count++;
         $display("[ERR] %0t timeout", $time);
         end_sim();
      end
      if (pready === 1'b1) begin
         x = q.pop_front();
         cmp({31'h0, pslverr}, {31'h0, x.e});
         if (x.c) cmp(prdata, x.d);
      end
   end
   initial begin
      s = $urandom(23);
      repeat (12) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      rd(FSR_OFF_STATUS_TWO, 32'h0, 1'b0);
      // Every combination of the three suspend levels
      for (int i = 0; i < 8; i++) begin
         csusp <= i[2];
         esusp <= i[1];
         psusp <= i[0];
         repeat (3) @(posedge clk_sys_i);
         rd(FSR_OFF_STATUS_TWO, {27'h0, i[2], 2'h0, i[1], i[0]}, 1'b0);
      end
      {csusp, esusp, psusp} <= 3'h0;
      busy <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rd(FSR_OFF_STATUS_ONE, 32'h1, 1'b0);
      busy <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rd(FSR_OFF_STATUS_ONE, 32'h0, 1'b0);
      // Span boundary: one short, exact minimum, wrapped sum
      s = $urandom() & 32'h7FFF_FFFF;
      crc(s, s + 32'h2);
      rd(FSR_OFF_STATUS_TWO, 32'h8, 1'b0);
      crc(s, s + 32'h3);
      rd(FSR_OFF_STATUS_TWO, 32'h0, 1'b0);
      crc(32'hFFFF_FFFF, 32'h1);
      rd(FSR_OFF_STATUS_TWO, 32'h8, 1'b0);
      // Evaluation first, then the result bit is read
      for (int i = 1; i >= 0; i--) begin
         serased <= i[0];
         edone <= 1'b1;
         @(posedge clk_sys_i);
         edone <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
         rd(FSR_OFF_STATUS_TWO, {29'h1, i[0], 2'h0}, 1'b0);
      end
      wr(FSR_OFF_STATUS_TWO, $urandom(), 1'b0);
      rd(FSR_OFF_STATUS_TWO, 32'h8, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      // Interrupt: raise, clear, mask, unmask
      wr(FSR_OFF_IRQ_ENABLE, 32'hF, 1'b0);
      rd(FSR_OFF_IRQ_ENABLE, 32'hF, 1'b0);
      rd(FSR_OFF_IRQ_STATUS, 32'hF, 1'b0);
      cmp({31'h0, irq}, 32'h1);
      wr(FSR_OFF_IRQ_CLEAR, 32'hF, 1'b0);
      rd(FSR_OFF_IRQ_STATUS, 32'h0, 1'b0);
      cmp({31'h0, irq}, 32'h0);
      rd(FSR_OFF_IRQ_CLEAR, 32'h0, 1'b1);
      wr(FSR_OFF_IRQ_ENABLE, 32'h0, 1'b0);
      crc(s, s);
      cmp({31'h0, irq}, 32'h0);
      rd(FSR_OFF_IRQ_STATUS, 32'h1, 1'b0);
      wr(FSR_OFF_IRQ_ENABLE, 32'h1, 1'b0);
      repeat (2) @(posedge clk_sys_i);
      cmp({31'h0, irq}, 32'h1);
      end_sim();
   end
endmodule : flash_status_register_two_bench
bind fsr_status_two fsr_status_two_assertions i_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .embedded_busy_i(embedded_busy_i), .crc_suspended_i(crc_suspended_i), .crc_req_i(crc_req_i),
   .crc_start_address_i(crc_start_address_i), .crc_end_address_i(crc_end_address_i),
   .erase_eval_done_i(erase_eval_done_i), .sector_erased_i(sector_erased_i),
   .erase_suspended_i(erase_suspended_i), .program_suspended_i(program_suspended_i), .crc_run_o(crc_run_o),
   .operation_status_two_o(operation_status_two_o), .ready_busy_flag_o(ready_busy_flag_o));
